/* hw/mvic_flags.sv */
`timescale 1ns/1ps
module mvic_flags
   import mvic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic [NUM_SRC-1:0] src_clear,
   input wire logic [NUM_SRC-1:0] src_enable,
   output logic [NUM_SRC-1:0] pending,
   mvic_src_if.producer req
);
   // Set wins over clear so a same-cycle event is not lost
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= '0;
      end else begin
         pending <= (pending & ~src_clear) | src_event;
      end
   end

   always_comb begin
      req.vec_req = '0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (pending[s] && src_enable[s]) begin
            req.vec_req[SRC_VEC[s]] = 1'b1;
         end
      end
   end
endmodule

/* hw/mvic_pkg.sv */
package mvic_pkg;
   localparam int NUM_SRC = 16;
   localparam int NUM_VEC = 10;
   localparam int VEC_W = 4;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [VEC_W-1:0] VEC_NONE = 4'hF;
   // Source bit positions
   localparam int SRC_EXT_A = 0;
   localparam int SRC_EXT_B = 1;
   localparam int SRC_EXT_C = 2;
   localparam int SRC_TIMER0_LOW = 3;
   localparam int SRC_EXT_E = 4;
   localparam int SRC_EXT_D = 5;
   localparam int SRC_EXT_F = 6;
   localparam int SRC_TIMER0_HIGH = 7;
   localparam int SRC_SYNC_SERIAL = 8;
   localparam int SRC_TIMER1_LOW = 9;
   localparam int SRC_TIMER1_HIGH = 10;
   localparam int SRC_PULSE_COUNTER_1 = 11;
   localparam int SRC_PULSE_COUNTER_2 = 12;
   localparam int SRC_ADC = 13;
   localparam int SRC_FAST_PWM_STOP = 14;
   localparam int SRC_FAST_PWM_PERIOD = 15;
   // Vector of each source
   localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{
      4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4,
      4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8};
   // Vectors that may take the highest level
   localparam int NUM_TOP_VEC = 2;
   typedef enum logic [1:0] {
      MVIC_LVL_NONE = 2'h0,
      MVIC_LVL_LOW = 2'h1,
      MVIC_LVL_HIGH = 2'h2,
      MVIC_LVL_TOP = 2'h3
   } mvic_lvl_t;
endpackage

/* hw/mvic_src_if.sv */
`timescale 1ns/1ps
interface mvic_src_if;
   logic [9:0] vec_req;
   modport producer(output vec_req);
   modport consumer(input vec_req);
endinterface

/* hw/mvic_top.sv */
`timescale 1ns/1ps
// What this block does
// - Sixteen sources share nine of the ten vector addresses
// - Three levels; first two vectors top/low
// - Equal or lower level than service refused
// - Highest pending level wins
// - Same level: smallest vector address wins
// - Vectors eight bytes apart from 0003H
module mvic_top
   import mvic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic [NUM_SRC-1:0] src_clear,
   input wire logic [NUM_SRC-1:0] src_enable,
   input wire logic [NUM_VEC-1:0] vec_hi_sel,
   input wire logic int_ack,
   input wire logic int_return,
   output logic [NUM_SRC-1:0] src_pending,
   output logic irq_valid,
   output logic [15:0] irq_addr,
   output logic [VEC_W-1:0] irq_vec,
   output logic [1:0] irq_level,
   output logic [1:0] active_level
);
   mvic_src_if req_bus();
   logic [NUM_SRC-1:0] pending;
   logic missed_higher;
   logic missed_smaller;
   logic [1:0] stk [3];
   logic [1:0] depth;
   logic found;
   logic [VEC_W-1:0] next_vec;
   mvic_lvl_t next_lvl;
   mvic_lvl_t cur_lvl;

   mvic_flags u_flags (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .src_event(src_event),
      .src_clear(src_clear),
      .src_enable(src_enable),
      .pending(pending),
      .req(req_bus.producer)
   );

   // Select bit picks top (vectors 0,1) or high (others); clear means low
   function automatic mvic_lvl_t vec_level(input int v, input logic sel);
      if (!sel) begin
         return MVIC_LVL_LOW;
      end else if (v < NUM_TOP_VEC) begin
         return MVIC_LVL_TOP;
      end else begin
         return MVIC_LVL_HIGH;
      end
   endfunction

   assign cur_lvl = (depth == 2'h0) ? MVIC_LVL_NONE : mvic_lvl_t'(stk[depth - 2'h1]);

   // Scan downward so the smallest vector of the best level survives
   always_comb begin
      found = 1'b0;
      next_vec = VEC_NONE;
      next_lvl = MVIC_LVL_NONE;
      for (int v = NUM_VEC - 1; v >= 0; v--) begin
         if (req_bus.vec_req[v] && vec_level(v, vec_hi_sel[v]) > cur_lvl &&
             vec_level(v, vec_hi_sel[v]) >= next_lvl) begin
            found = 1'b1;
            next_vec = VEC_W'(v);
            next_lvl = vec_level(v, vec_hi_sel[v]);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_valid <= 1'b0;
         irq_vec <= VEC_NONE;
         irq_addr <= 16'h0000;
         irq_level <= 2'h0;
      end else begin
         irq_valid <= found && !int_ack;
         irq_vec <= next_vec;
         irq_level <= next_lvl;
         irq_addr <= VEC_BASE + VEC_STEP * {12'h000, next_vec};
      end
   end

   // Service level stack: pushed on acknowledge, popped on return.
   // Depth three suffices since only strictly higher levels nest.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         depth <= 2'h0;
         stk[0] <= 2'h0;
         stk[1] <= 2'h0;
         stk[2] <= 2'h0;
      end else if (int_ack && irq_valid && irq_level > cur_lvl) begin
         stk[depth] <= irq_level;
         depth <= depth + 2'h1;
      end else if (int_return && depth != 2'h0) begin
         depth <= depth - 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_level <= 2'h0;
         src_pending <= '0;
      end else begin
         active_level <= cur_lvl;
         src_pending <= pending;
      end
   end

   // Checker helpers: an eligible vector that the pick passed over
   always_comb begin
      missed_higher = 1'b0;
      missed_smaller = 1'b0;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (req_bus.vec_req[v] && vec_level(v, vec_hi_sel[v]) > cur_lvl) begin
            if (vec_level(v, vec_hi_sel[v]) > next_lvl) begin
               missed_higher = 1'b1;
            end
            if (vec_level(v, vec_hi_sel[v]) == next_lvl && VEC_W'(v) < next_vec) begin
               missed_smaller = 1'b1;
            end
         end
      end
   end

   property p_no_low_nest;
      @(posedge sys_clk) disable iff (!rst_n)
      irq_valid |-> irq_level > active_level;
   endproperty
   a_no_low_nest: assert property (p_no_low_nest) else $error("nest not higher");

   property p_addr_map;
      @(posedge sys_clk) disable iff (!rst_n)
      found |=> irq_addr == VEC_BASE + VEC_STEP * {12'h000, $past(next_vec)};
   endproperty
   a_addr_map: assert property (p_addr_map) else $error("bad vector address");

   property p_top_only_low_vec;
      @(posedge sys_clk) disable iff (!rst_n)
      irq_valid && irq_level == MVIC_LVL_TOP |-> irq_vec < NUM_TOP_VEC;
   endproperty
   a_top_only_low_vec: assert property (p_top_only_low_vec) else $error("bad top");

   property p_sticky;
      @(posedge sys_clk) disable iff (!rst_n)
      src_event[SRC_EXT_A] |=> pending[SRC_EXT_A];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");

   property p_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      pending[SRC_ADC] && !src_clear[SRC_ADC] |=> pending[SRC_ADC];
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped");

   property p_ext_c_vec;
      @(posedge sys_clk) disable iff (!rst_n)
      pending[SRC_EXT_C] && src_enable[SRC_EXT_C] |-> req_bus.vec_req[2];
   endproperty
   a_ext_c_vec: assert property (p_ext_c_vec) else $error("no request");

   property p_level_first;
      @(posedge sys_clk) disable iff (!rst_n)
      found && req_bus.vec_req[0] && vec_hi_sel[0] && depth == 2'h0
         |-> next_vec == 4'h0;
   endproperty
   a_level_first: assert property (p_level_first) else $error("top lost");

   property p_smallest;
      @(posedge sys_clk) disable iff (!rst_n)
      req_bus.vec_req[2] && req_bus.vec_req[3] && !vec_hi_sel[2] && !vec_hi_sel[3]
         && found && next_lvl == MVIC_LVL_LOW |-> next_vec != 4'h3;
   endproperty
   a_smallest: assert property (p_smallest) else $error("not smallest");

   property p_best_level;
      @(posedge sys_clk) disable iff (!rst_n)
      !missed_higher;
   endproperty
   a_best_level: assert property (p_best_level) else $error("higher level skipped");

   property p_first_of_level;
      @(posedge sys_clk) disable iff (!rst_n)
      !missed_smaller;
   endproperty
   a_first_of_level: assert property (p_first_of_level) else $error("larger vector won");

   property p_valid_follows;
      @(posedge sys_clk) disable iff (!rst_n)
      found && !int_ack |=> irq_valid;
   endproperty
   a_valid_follows: assert property (p_valid_follows) else $error("request not shown");

   property p_ack_drops;
      @(posedge sys_clk) disable iff (!rst_n)
      int_ack |=> !irq_valid;
   endproperty
   a_ack_drops: assert property (p_ack_drops) else $error("request after ack");

   property p_push_level;
      @(posedge sys_clk) disable iff (!rst_n)
      int_ack && irq_valid && irq_level > cur_lvl |=> cur_lvl == $past(irq_level);
   endproperty
   a_push_level: assert property (p_push_level) else $error("service level not taken");

   property p_pop_level;
      @(posedge sys_clk) disable iff (!rst_n)
      int_return && depth != 2'h0 && !(int_ack && irq_valid && irq_level > cur_lvl)
         |=> depth == $past(depth) - 2'h1;
   endproperty
   a_pop_level: assert property (p_pop_level) else $error("service level not released");

   // Tenth vector has no source behind it
   property p_spare_vec;
      @(posedge sys_clk) disable iff (!rst_n)
      !req_bus.vec_req[NUM_VEC-1];
   endproperty
   a_spare_vec: assert property (p_spare_vec) else $error("spare vector requested");

   c_nest: cover property (@(posedge sys_clk) disable iff (!rst_n) depth == 2'h2);
   c_low_nest: cover property (@(posedge sys_clk) disable iff (!rst_n)
      depth == 2'h1 && cur_lvl == MVIC_LVL_LOW);
   c_top: cover property (@(posedge sys_clk) disable iff (!rst_n)
      irq_valid && irq_level == MVIC_LVL_TOP);
   c_ret: cover property (@(posedge sys_clk) disable iff (!rst_n) int_return && depth != 2'h0);
endmodule

/* tb/multilevel_vectored_interrupt_ctrl_bench.sv */
`timescale 1ns/1ps
module multilevel_vectored_interrupt_ctrl_bench;
   import mvic_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] ev = '0, clr = '0, en = '0, pend = '0, src_pending, irq_addr;
   logic [9:0] hi = '0;
   logic take = 1'b0, leave = 1'b0, int_ack, int_return, irq_valid;
   logic [3:0] irq_vec;
   logic [1:0] irq_level, active_level;
   int failures = 0, checks_done = 0, cycles = 0;
   always #2 sys_clk = ~sys_clk;
   mvic_top u_mvic_top (.sys_clk(sys_clk), .rst_n(rst_n), .src_event(ev), .src_clear(clr),
      .src_enable(en), .vec_hi_sel(hi), .int_ack(int_ack), .int_return(int_return),
      .src_pending(src_pending), .irq_valid(irq_valid), .irq_addr(irq_addr),
      .irq_vec(irq_vec), .irq_level(irq_level), .active_level(active_level));
   mvic_core_model u_mvic_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .irq_valid(irq_valid),
      .take(take), .leave(leave), .int_ack(int_ack), .int_return(int_return));
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Set beats clear in the same cycle
   task automatic fire(logic [15:0] e, logic [15:0] c);
      ev = e;
      clr = c;
      pend = (pend & ~c) | e;
      cyc(1);
      ev = '0;
      clr = '0;
      cyc(3);
   endtask
   task automatic pulse(logic t);
      take = t;
      leave = !t;
      cyc(1);
      take = 1'b0;
      leave = 1'b0;
      cyc(3);
   endtask
   function automatic logic [5:0] pick(logic [15:0] p, logic [15:0] e, logic [9:0] h,
         logic [1:0] act);
      logic [9:0] rq;
      logic [1:0] best, l;
      logic [3:0] bv;
      rq = '0;
      best = act;
      bv = VEC_NONE;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (p[s] && e[s]) begin
            rq[SRC_VEC[s]] = 1'b1;
         end
      end
      // Ascending scan with strict compare keeps the smallest vector
      for (int v = 0; v < NUM_VEC; v++) begin
         l = !rq[v] ? 2'h0 : !h[v] ? 2'h1 : (v < NUM_TOP_VEC) ? 2'h3 : 2'h2;
         if (l > best) begin
            best = l;
            bv = 4'(v);
         end
      end
      return {(bv == VEC_NONE) ? 2'h0 : best, bv};
   endfunction
   task automatic verify(logic [1:0] act);
      logic [5:0] x;
      x = pick(pend, en, hi, act);
      chk(16'(irq_valid), 16'(x[3:0] != VEC_NONE));
      chk(16'(irq_vec), 16'(x[3:0]));
      chk(src_pending, pend);
      if (x[3:0] != VEC_NONE) begin
         chk(16'(irq_level), 16'(x[5:4]));
         chk(irq_addr, VEC_BASE + VEC_STEP * 16'(x[3:0]));
      end
   endtask
   task final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      void'($urandom(44));
      cyc(4);
      rst_n = 1'b1;
      cyc(1);
      for (int i = 0; i < 80; i++) begin
         en = 16'($urandom);
         hi = 10'($urandom);
         fire(16'($urandom & $urandom & $urandom), 16'($urandom & $urandom));
         verify(2'h0);
      end
      en = '1;
      hi = '1;
      fire('0, '1);
      fire(16'h0001 << SRC_EXT_C, '0);
      verify(2'h0);
      pulse(1'b1);
      chk(16'(active_level), 16'h0002);
      fire(16'h0001 << SRC_TIMER0_HIGH, '0);
      verify(2'h2);
      fire(16'h0001 << SRC_EXT_A, '0);
      verify(2'h2);
      pulse(1'b1);
      chk(16'(active_level), 16'h0003);
      fire('0, 16'h0001 << SRC_EXT_A);
      pulse(1'b0);
      chk(16'(active_level), 16'h0002);
      verify(2'h2);
      fire('0, '1);
      pulse(1'b0);
      chk(16'(active_level), 16'h0000);
      verify(2'h0);
      hi = '0;
      fire(16'h0001 << SRC_EXT_D, '0);
      verify(2'h0);
      pulse(1'b1);
      chk(16'(active_level), 16'h0001);
      hi = 10'h020;
      fire(16'h0001 << SRC_TIMER1_LOW, '0);
      verify(2'h1);
      fire('0, '1);
      pulse(1'b0);
      chk(16'(active_level), 16'h0000);
      final_report();
   end
endmodule

/* tb/mvic_core_model.sv */
`timescale 1ns/1ps
module mvic_core_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic irq_valid,
   input wire logic take,
   input wire logic leave,
   output logic int_ack,
   output logic int_return
);
   // One pulse each; ack only a live request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_ack <= 1'b0;
         int_return <= 1'b0;
      end else begin
         int_ack <= take && irq_valid && !int_ack;
         int_return <= leave && !int_return;
      end
   end
endmodule
